// ==== src/clock_enable_pkg.sv ====
/*
  Constants shared by the serial-configured clock output enable block:
  frame layout, device address, enable bit positions and reset values.
  Assumes a fixed ten-byte write frame and thirteen gated outputs.
*/
package clock_enable_pkg;

  localparam int NUM_OUTPUTS = 13;
  localparam int BYTE_BITS = 8;
  localparam int FRAME_BYTES = 10;

  // Write address: seven address bits plus a low write bit
  localparam logic [7:0] DEVICE_ADDR_WR = 8'hd2;

  // Byte positions inside a frame, counted from zero
  localparam logic [3:0] BYTE_ADDR = 4'h0;
  localparam logic [3:0] BYTE_COMMAND = 4'h1;
  localparam logic [3:0] BYTE_COUNT = 4'h2;
  localparam logic [3:0] BYTE_GROUP_A = 4'h3;
  localparam logic [3:0] BYTE_GROUP_B = 4'h4;
  localparam logic [3:0] BYTE_GROUP_C = 4'h5;
  localparam logic [3:0] BYTE_LAST = 4'h9;

  // Bit counter value at which the acknowledge clock follows
  localparam logic [3:0] BITS_DONE = 4'h8;

  // Enable bit positions in group a
  localparam int GA_OUT5 = 7;
  localparam int GA_OUT4 = 6;
  localparam int GA_OUT3_0_LSB = 0;
  // Enable bit positions in group b
  localparam int GB_OUT11_8_LSB = 4;
  localparam int GB_OUT7_6_LSB = 0;
  // Enable bit position in group c
  localparam int GC_OUT12 = 6;

  // All outputs run from power-up
  localparam logic [12:0] ENABLES_RESET = 13'h1fff;

  // Indices of the three configuration groups
  localparam int GROUP_A = 0;
  localparam int GROUP_B = 1;
  localparam int GROUP_C = 2;
  localparam int NUM_GROUPS = 3;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_RECV = 2'b01,
    LINK_IGNORE = 2'b10
  } link_mode_type;

endpackage

// ==== src/gate_ctrl_if.sv ====
/*
  Carrier for the enable vector from the serial receiver to the gate bank.
  Assumes both ends sit in the reference clock domain.
*/
`timescale 1ns/1ns
interface gate_ctrl_if #(
  parameter int N = 13
);
  logic [N-1:0] enables;
  modport source (output enables);
  modport sink (input enables);
endinterface

// ==== src/clock_gate_bank.sv ====
/*
  Gate bank: thirteen copies of the reference clock, each gated by its
  enable. Assumes the enables are stable in the reference clock domain.
*/
`timescale 1ns/1ns
module clock_gate_bank
  import clock_enable_pkg::*;
#(
  parameter int N = NUM_OUTPUTS
) (
  // Reference clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Enable vector
  gate_ctrl_if.sink ctrl,
  // Gated copies
  output logic [N-1:0] gated_clock_outputs
);

  typedef struct packed {
    logic [N-1:0] enables;
  } gate_regs_type;

  gate_regs_type gate_reg;
  gate_regs_type gate_next;

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    gate_next = gate_reg;
    if (sys_rst) begin
      gate_next.enables = ENABLES_RESET[N-1:0];
    end else begin
      gate_next.enables = ctrl.enables;
    end
  end

  // Falling edge: enables move only while the clock is low, so no runt
  always_ff @(negedge clk) begin
    gate_reg <= gate_next;
  end

  ////////////////////////////////////////////////////////////////////////

  // Disabled outputs sit low rather than following the clock
  assign gated_clock_outputs = {N{clk}} & gate_reg.enables;

endmodule

// ==== src/smbus_clock_output_enable.sv ====
/*
  Top of the serial-configured clock output enable block: a write-only
  serial receiver on the host's bus clock, a crossing into the reference
  clock domain, and the gate bank. Assumes clk is the reference clock,
  an external pull-up on the data line, and a host that moves data only
  while the bus clock is low.
*/
`timescale 1ns/1ns

module smbus_clock_output_enable
  import clock_enable_pkg::*;
#(
  parameter logic [7:0] ADDRESS = DEVICE_ADDR_WR
) (
  // Reference clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial bus clock, input only
  input wire logic serial_clock_line,
  // Serial data line, open drain
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  // Gated clock outputs
  output logic [NUM_OUTPUTS-1:0] gated_clock_outputs
);

  ////////////////////////////////////////////////////////////////////////
  // Link-side state, clocked by the bus clock

  typedef struct packed {
    link_mode_type mode;
    logic [3:0] bit_cnt;
    logic [3:0] byte_idx;
    logic [7:0] shift;
    logic matched;
    logic start_seen;
    logic stop_seen;
    logic [NUM_GROUPS-1:0] upd_tog;
    logic [7:0] hold_a;
    logic [7:0] hold_b;
    logic [7:0] hold_c;
  } link_regs_type;

  typedef struct packed {
    logic ack;
  } ack_regs_type;

  // One toggle per bus condition, clocked by data line edges
  typedef struct packed {
    logic tog;
  } cond_regs_type;

  typedef struct packed {
    logic [NUM_GROUPS-1:0] sync1;
    logic [NUM_GROUPS-1:0] sync2;
    logic [NUM_GROUPS-1:0] seen;
    logic [NUM_OUTPUTS-1:0] enables;
  } core_regs_type;

  link_regs_type link_reg;
  link_regs_type link_next;
  ack_regs_type ack_reg;
  ack_regs_type ack_next;
  core_regs_type core_reg;
  core_regs_type core_next;
  cond_regs_type start_reg;
  cond_regs_type start_next;
  cond_regs_type stop_reg;
  cond_regs_type stop_next;
  logic new_start;
  logic new_stop;

  gate_ctrl_if #(.N(NUM_OUTPUTS)) gate_ctrl ();

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Merge one configuration byte into the enable vector
  function automatic logic [NUM_OUTPUTS-1:0] apply_group(
    input logic [NUM_OUTPUTS-1:0] en,
    input int group,
    input logic [7:0] cfg
  );
    logic [NUM_OUTPUTS-1:0] res;
    res = en;
    case (group)
      GROUP_A: begin
        res[5] = cfg[GA_OUT5];
        res[4] = cfg[GA_OUT4];
        res[3:0] = cfg[GA_OUT3_0_LSB +: 4];
      end
      GROUP_B: begin
        res[11:8] = cfg[GB_OUT11_8_LSB +: 4];
        res[7:6] = cfg[GB_OUT7_6_LSB +: 2];
      end
      GROUP_C: begin
        res[12] = cfg[GC_OUT12];
      end
      default: begin
        res = en;
      end
    endcase
    return res;
  endfunction

  // Held byte of one group, read once its toggle has crossed over
  function automatic logic [7:0] held_byte(
    input link_regs_type r,
    input int group
  );
    logic [7:0] res;
    case (group)
      GROUP_B: begin
        res = r.hold_b;
      end
      GROUP_C: begin
        res = r.hold_c;
      end
      default: begin
        res = r.hold_a;
      end
    endcase
    return res;
  endfunction

  // Acknowledge due after the eighth bit of the current byte
  function automatic logic ack_due(input link_regs_type r);
    logic due;
    due = 1'b0;
    if (r.mode == LINK_RECV && r.bit_cnt == BITS_DONE) begin
      if (r.byte_idx == BYTE_ADDR) begin
        due = (r.shift == ADDRESS);
      end else begin
        due = r.matched;
      end
    end
    return due;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Start and stop detection on data edges while the bus clock is high.
  // Toggles, not levels: the bus clock domain cannot clear them, so it
  // compares against its own copy instead.

  // A data edge counts only while the bus clock is high
  always_comb begin
    start_next = start_reg;
    if (serial_clock_line) begin
      start_next.tog = ~start_reg.tog;
    end
  end

  always_ff @(negedge serial_data_line_in or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= '0;
    end else begin
      start_reg <= start_next;
    end
  end

  // A rising data edge with the bus clock high ends the frame
  always_comb begin
    stop_next = stop_reg;
    if (serial_clock_line) begin
      stop_next.tog = ~stop_reg.tog;
    end
  end

  always_ff @(posedge serial_data_line_in or posedge sys_rst) begin
    if (sys_rst) begin
      stop_reg <= '0;
    end else begin
      stop_reg <= stop_next;
    end
  end

  // Toggles settle while the clock is high, long before the next rise
  assign new_start = start_reg.tog ^ link_reg.start_seen;
  assign new_stop = stop_reg.tog ^ link_reg.stop_seen;

  ////////////////////////////////////////////////////////////////////////
  // Byte receiver, sampling data on the rising bus clock

  always_comb begin
    link_next = link_reg;
    link_next.start_seen = start_reg.tog;
    link_next.stop_seen = stop_reg.tog;
    if (new_start) begin
      // First address bit arrives on the first rise after a start
      link_next.mode = LINK_RECV;
      link_next.bit_cnt = 4'h1;
      link_next.byte_idx = BYTE_ADDR;
      link_next.shift = {7'h00, serial_data_line_in};
      link_next.matched = 1'b0;
    end else if (new_stop) begin
      link_next.mode = LINK_IDLE;
      link_next.bit_cnt = 4'h0;
    end else begin
      case (link_reg.mode)
        LINK_RECV: begin
          if (link_reg.bit_cnt == BITS_DONE) begin
            // Acknowledge clock: the byte is complete
            link_next.bit_cnt = 4'h0;
            if (link_reg.byte_idx == BYTE_ADDR) begin
              link_next.matched = (link_reg.shift == ADDRESS);
              if (link_reg.shift != ADDRESS) begin
                link_next.mode = LINK_IGNORE;
              end
            end else if (link_reg.matched) begin
              // Command and count bytes fall through untouched
              case (link_reg.byte_idx)
                BYTE_GROUP_A: begin
                  link_next.hold_a = link_reg.shift;
                  link_next.upd_tog[GROUP_A] = ~link_reg.upd_tog[GROUP_A];
                end
                BYTE_GROUP_B: begin
                  link_next.hold_b = link_reg.shift;
                  link_next.upd_tog[GROUP_B] = ~link_reg.upd_tog[GROUP_B];
                end
                BYTE_GROUP_C: begin
                  link_next.hold_c = link_reg.shift;
                  link_next.upd_tog[GROUP_C] = ~link_reg.upd_tog[GROUP_C];
                end
                default: begin
                  link_next.hold_a = link_reg.hold_a;
                end
              endcase
            end
            if (link_reg.byte_idx == BYTE_LAST) begin
              link_next.mode = LINK_IDLE;
            end else begin
              link_next.byte_idx = link_reg.byte_idx + 4'h1;
            end
          end else begin
            link_next.shift = {link_reg.shift[6:0], serial_data_line_in};
            link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
          end
        end
        LINK_IGNORE: begin
          link_next.bit_cnt = 4'h0;
        end
        default: begin
          link_next.bit_cnt = 4'h0;
        end
      endcase
    end
  end

  // The bus clock may stand still, so reset cannot wait for its edges
  always_ff @(posedge serial_clock_line or posedge sys_rst) begin
    if (sys_rst) begin
      link_reg <= '{mode: LINK_IDLE, hold_a: 8'hff, hold_b: 8'hff,
                    hold_c: 8'hff, default: '0};
    end else begin
      link_reg <= link_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge driver, moving on the falling bus clock so the data line
  // changes only while the clock is low

  always_comb begin
    ack_next = ack_reg;
    ack_next.ack = ack_due(link_reg);
  end

  always_ff @(negedge serial_clock_line or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= '{default: '0};
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Open drain: the line is only ever pulled low, never driven high
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_n = ~ack_reg.ack;

  ////////////////////////////////////////////////////////////////////////
  // Crossing into the reference domain: one toggle per group, two flops,
  // then the held byte is copied. The held byte changes at most once per
  // frame, so it is long stable when the toggle arrives.

  always_comb begin
    core_next = core_reg;
    core_next.sync1 = link_reg.upd_tog;
    core_next.sync2 = core_reg.sync1;
    core_next.seen = core_reg.sync2;
    if (core_reg.sync2[GROUP_A] ^ core_reg.seen[GROUP_A]) begin
      core_next.enables = apply_group(core_next.enables, GROUP_A,
                                      held_byte(link_reg, GROUP_A));
    end
    if (core_reg.sync2[GROUP_B] ^ core_reg.seen[GROUP_B]) begin
      core_next.enables = apply_group(core_next.enables, GROUP_B,
                                      held_byte(link_reg, GROUP_B));
    end
    if (core_reg.sync2[GROUP_C] ^ core_reg.seen[GROUP_C]) begin
      core_next.enables = apply_group(core_next.enables, GROUP_C,
                                      held_byte(link_reg, GROUP_C));
    end
    if (sys_rst) begin
      core_next = '{enables: ENABLES_RESET, default: '0};
    end
  end

  always_ff @(posedge clk) begin
    core_reg <= core_next;
  end

  assign gate_ctrl.enables = core_reg.enables;

  ////////////////////////////////////////////////////////////////////////

  clock_gate_bank #(
    .N(NUM_OUTPUTS)
  ) u_gate_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .ctrl(gate_ctrl),
    .gated_clock_outputs(gated_clock_outputs)
  );

endmodule

// ==== tb/smbus_clock_output_enable_props.sv ====
/*
  Checker for the clock output enable block top ports.
  Assumes the bind below; bus clock idles high.
*/
`timescale 1ns/1ns
module smbus_clock_output_enable_props
  import clock_enable_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clock_line,
  // Serial data
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe_n,
  // Outputs
  input wire logic [NUM_OUTPUTS-1:0] gated_clock_outputs
);
  logic [3:0] quiet_reg;
  // Async clear: an ack is shorter than one clk period
  always_ff @(posedge clk or negedge serial_data_line_oe_n) begin
    if (!serial_data_line_oe_n) begin
      quiet_reg <= 4'h0;
    end else if (sys_rst) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  sequence ack_bit;
    !serial_data_line_oe_n;
  endsequence
  sequence byte_bits;
    serial_data_line_oe_n [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////
  out_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    gated_clock_outputs == '0) else $error("output high with clk low");
  drive_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    serial_data_line_out == 1'b0) else $error("data driven high");
  ack_single_a: assert property (@(posedge serial_clock_line)
    disable iff (sys_rst) ack_bit |=> serial_data_line_oe_n)
    else $error("ack longer than one clock");
  ack_gap_a: assert property (@(posedge serial_clock_line)
    disable iff (sys_rst) ack_bit |=> byte_bits)
    else $error("ack inside a byte");
  ack_after_byte_a: assert property (@(posedge serial_clock_line)
    disable iff (sys_rst) ack_bit |-> $past(serial_data_line_oe_n, 1)
    && $past(serial_data_line_oe_n, 8)) else $error("early ack");
  reset_oe_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> serial_data_line_oe_n) else $error("drive in reset");
  reset_all_on_a: assert property (@(negedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> gated_clock_outputs == ENABLES_RESET)
    else $error("outputs not all on");
  cfg_quiet_a: assert property (@(negedge clk) disable iff (sys_rst)
    quiet_reg > 4'h8 |-> $stable(gated_clock_outputs))
    else $error("enable change without ack");
endmodule
bind smbus_clock_output_enable smbus_clock_output_enable_props u_props (
  .clk(clk), .sys_rst(sys_rst), .serial_clock_line(serial_clock_line),
  .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe_n(serial_data_line_oe_n),
  .gated_clock_outputs(gated_clock_outputs));

// ==== tb/smbus_host_model.sv ====
/*
  Bus host model: start, bytes with ack sampling, stop; 12 ns bus clock.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
module smbus_host_model (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Clock stands high between frames, as the pull-up leaves it
  task automatic put_bit(input logic b, output logic seen);
    #1 sda_low = !b;
    #5 scl = 1'b1;
    seen = sda;
    #6 scl = 1'b0;
  endtask
  task automatic send_frame(input logic [7:0] f [10], input int nb,
                            output int acks);
    logic s;
    acks = 0;
    sda_low = 1'b1;
    #6 scl = 1'b0;
    for (int i = 0; i < nb; i++) begin
      for (int k = 7; k >= 0; k--) put_bit(f[i][k], s);
      put_bit(1'b1, s);
      if (s === 1'b0) acks++;
      else if (s !== 1'b1) acks += 100;
    end
    #1 sda_low = 1'b1;
    #5 scl = 1'b1;
    #6 sda_low = 1'b0;
    #12;
  endtask
endmodule

// ==== tb/test_smbus_clock_output_enable.sv ====
/*
  Self-checking bench: host model writes frames, a monitor compares
  gated outputs against queued expectations. Assumes 20 MHz clk.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_smbus_clock_output_enable;
  import clock_enable_pkg::*;
  logic clk, sys_rst, scl, host_low, sda, dout, oe_n;
  logic [12:0] gated, cur_en, hi, lo;
  logic [12:0] exp_q [$];
  logic [7:0] ga, gb, gc;
  int error_cnt = 0, cmp_count = 0, seed_val;
  event chk_ev;
  assign sda = (host_low || !oe_n) ? 1'b0 : 1'b1;
  smbus_clock_output_enable u_dut (.clk(clk), .sys_rst(sys_rst),
    .serial_clock_line(scl), .serial_data_line_in(sda),
    .serial_data_line_out(dout), .serial_data_line_oe_n(oe_n),
    .gated_clock_outputs(gated));
  smbus_host_model u_host (.scl(scl), .sda_low(host_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Monitor: high phase shows enables, low phase shows nothing
  initial forever begin
    @(chk_ev);
    @(posedge clk);
    #10 hi = gated;
    @(negedge clk);
    #10 lo = gated;
    `CHK("high phase", exp_q[0], hi)
    `CHK("low phase", 13'h0000, lo)
    void'(exp_q.pop_front());
  end
  task automatic run_frame(input logic [7:0] adr, input int nb,
                           input int exp_acks, input string nm);
    logic [7:0] f [10];
    int acks;
    for (int i = 1; i < 10; i++) f[i] = 8'($urandom);
    f[0] = adr;
    f[3] = ga;
    f[4] = gb;
    f[5] = gc;
    #3 u_host.send_frame(f, nb, acks);
    `CHK("ack count", exp_acks, acks)
    repeat (5) @(negedge clk);
    exp_q.push_back(cur_en);
    ->chk_ev;
    repeat (3) @(negedge clk);
    $display("test %s done", nm);
  endtask
  task automatic reset_check(input string nm);
    sys_rst <= 1'b1;
    repeat (5) @(negedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    cur_en = ENABLES_RESET;
    exp_q.push_back(cur_en);
    ->chk_ev;
    repeat (3) @(negedge clk);
    $display("test %s done", nm);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
  initial begin
    sys_rst = 1'b1;
    seed_val = $urandom(32'h8d93);
    reset_check("reset");
    for (int i = 0; i < 8; i++) begin
      ga = (i == 0) ? 8'h00 : 8'($urandom) & 8'hcf;
      gb = (i == 0) ? 8'h00 : 8'($urandom) & 8'hf3;
      gc = (i == 1) ? 8'h40 : 8'($urandom) & 8'h40;
      cur_en = {gc[6], gb[7:4], gb[1:0], ga[7:6], ga[3:0]};
      run_frame(DEVICE_ADDR_WR, 10, 10, "write");
    end
    ga = ~ga & 8'hcf;
    run_frame(DEVICE_ADDR_WR ^ (8'h01 << $urandom_range(0, 7)), 10, 0,
      "foreign");
    cur_en[7:0] = {cur_en[7:6], ga[7:6], ga[3:0]};
    run_frame(DEVICE_ADDR_WR, 4, 4, "short");
    reset_check("mid reset");
    cur_en = {gc[6], gb[7:4], gb[1:0], ga[7:6], ga[3:0]};
    run_frame(DEVICE_ADDR_WR, 10, 10, "after reset");
    end_sim;
  end
endmodule
